// *** core/pwi_slave.sv ***
/*
 * wiper slave end: decodes start/stop, matches the identification byte,
 * acknowledges, stores the 7-bit wiper and returns it on a read.
 * assumes the link lines come from another clock domain; both pass two flops.
 */
`timescale 1ns/1ps
// Operation
// - bytes travel msb first
// - data changes only while clock low
// - start is sda fall, scl high; idle otherwise
// - master ends each operation with stop
// - stop after read or write gives standby
// - data pin released after power-up
// - receiver pulls data low in ninth clock
// - ack identification byte and address byte
// - ack each written data byte
// - id must match pattern and select pins
// - id lsb one reads, zero writes
// - write is id, address, data, stop
// - after read ack, shift out wiper
// - master nacks read byte then stops
// - exactly one data byte per read
// - slave only, never drives clock
// - sample on rise, change after fall
// - address zero writes only the wiper
// - wiper is seven bits, 00h to 7Fh
// - wiper resets to 20h
module pwi_slave
    import pwi_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // link
    pwi_bus_if.slave                bus,
    // select pins and wiper
    input  wire logic               addr_select_hi_pin_i,
    input  wire logic               addr_select_lo_pin_i,
    output logic [pwi_pkg::WIPER_W-1:0] wiper_o,
    output logic                    standby_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ID, ST_ADDR, ST_DATA, ST_ACK, ST_TX, ST_TXACK
    } pwi_state_e;

    pwi_state_e  state_q;
    pwi_state_e  after_ack_q;
    logic [1:0]  scl_sync_q;
    logic [1:0]  sda_sync_q;
    logic        scl_q;
    logic        sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic [7:0]  shift_q;
    logic [3:0]  bit_q;
    logic        rd_q;
    logic        addr_ok_q;
    logic        sda_oe_q;
    logic [WIPER_W-1:0] wiper_q;
    logic        standby_q;
    logic [7:0]  rx_byte;
    logic [1:0]  sel_meta_q;
    logic [1:0]  sel_q;

    // select pins are straps from outside the clock domain: two flops before use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_meta_q <= 2'h0;
            sel_q      <= 2'h0;
        end else begin
            sel_meta_q <= {addr_select_hi_pin_i, addr_select_lo_pin_i};
            sel_q      <= sel_meta_q;
        end
    end

    // two-flop synchronisers for the link lines
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], bus.scl};
            sda_sync_q <= {sda_sync_q[0], bus.sda};
            scl_q      <= scl_sync_q[1];
            sda_q      <= sda_sync_q[1];
        end
    end

    // edge and condition detection on synchronised levels
    assign scl_rise  = scl_sync_q[1] & ~scl_q;
    assign scl_fall  = ~scl_sync_q[1] & scl_q;
    assign start_det = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
    assign stop_det  = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];
    assign rx_byte   = {shift_q[6:0], sda_sync_q[1]};

    // protocol state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= ST_IDLE;
            after_ack_q <= ST_IDLE;
            shift_q     <= 8'h00;
            bit_q       <= 4'h0;
            rd_q        <= 1'b0;
            addr_ok_q   <= 1'b0;
            sda_oe_q    <= 1'b0;
        end else if (start_det) begin
            state_q  <= ST_ID;
            bit_q    <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;        // ignore everything until start
                end
                ST_ID, ST_ADDR, ST_DATA: begin
                    if (scl_rise) begin      // sample on rising clock
                        shift_q <= rx_byte;
                        bit_q   <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (state_q == ST_ID) begin
                            if (shift_q[7:3] == ID_PATTERN &&
                                shift_q[2:1] == sel_q) begin
                                rd_q        <= shift_q[0];
                                sda_oe_q    <= 1'b1;
                                after_ack_q <= shift_q[0] ? ST_TX : ST_ADDR;
                                state_q     <= ST_ACK;
                            end else begin
                                state_q <= ST_IDLE;  // not addressed: stay silent
                            end
                        end else if (state_q == ST_ADDR) begin
                            addr_ok_q   <= shift_q == WIPER_ADDR;
                            sda_oe_q    <= 1'b1;
                            after_ack_q <= ST_DATA;
                            state_q     <= ST_ACK;
                        end else begin
                            sda_oe_q    <= 1'b1;
                            after_ack_q <= ST_IDLE;
                            state_q     <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    // hold ack low through ninth clock; after its fall release, or on a read keep driving the zero msb
                    if (scl_fall) begin
                        state_q <= after_ack_q;
                        if (after_ack_q == ST_TX) begin
                            sda_oe_q <= 1'b1;                 // msb of byte is zero: pull low
                            shift_q  <= {1'b0, wiper_q};
                            bit_q    <= 4'h1;
                        end else begin
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    // shift next bit after each falling clock
                    if (scl_fall) begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        if (bit_q == 4'h8) begin
                            sda_oe_q <= 1'b0;                 // release for master nack
                            state_q  <= ST_TXACK;
                        end else begin
                            sda_oe_q <= ~shift_q[6];
                            bit_q    <= bit_q + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    // single byte only; go idle on the fall of the master's nack clock
                    if (scl_fall) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // wiper update on acknowledged data byte at address zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wiper_q <= WIPER_RESET;
        end else if (!start_det && !stop_det && state_q == ST_DATA && scl_fall
                     && bit_q == 4'h8 && addr_ok_q && !rd_q) begin
            wiper_q <= shift_q[WIPER_W-1:0];
        end
    end

    // standby flag: set by stop, cleared by start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_q <= 1'b1;
        end else if (start_det) begin
            standby_q <= 1'b0;
        end else if (stop_det) begin
            standby_q <= 1'b1;
        end
    end

    assign bus.sda_s_oe = sda_oe_q;    // open drain, clock never driven
    assign wiper_o      = wiper_q;
    assign standby_o    = standby_q;
endmodule : pwi_slave

// *** core/pwi_pkg.sv ***
/*
 * shared constants for the two-wire wiper interface: identification pattern,
 * wiper width and reset value, command width, fifo depth and divider timing.
 * assumes a 200 MHz system clock on both ends.
 */
package pwi_pkg;
    localparam logic [4:0] ID_PATTERN   = 5'h0a;   // 01010 fixed upper bits
    localparam int         WIPER_W      = 7;
    localparam logic [6:0] WIPER_RESET  = 7'h20;   // quarter-scale at power-up
    localparam logic [7:0] WIPER_ADDR   = 8'h00;   // only mapped address
    localparam int         CLK_PERIOD_NS = 5;
    localparam int         SCL_HALF_NS   = 2400;   // half period of generated link clock
    localparam int         SCL_QTR_CYC   = SCL_HALF_NS / CLK_PERIOD_NS / 2;
    localparam int         FIFO_DEPTH    = 16;
    localparam int         CMD_W         = 17;     // {rd, addr, data}
endpackage : pwi_pkg

// *** core/pwi_bus_if.sv ***
/*
 * open-drain two-wire link between master and wiper slave.
 * assumes pull-ups: a line is low when any party enables its driver.
 */
`timescale 1ns/1ps
interface pwi_bus_if;
    logic scl_oe;       // master pulls clock low
    logic sda_m_oe;     // master pulls data low
    logic sda_s_oe;     // slave pulls data low
    logic scl;
    logic sda;
    assign scl = ~scl_oe;
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport master (output scl_oe, output sda_m_oe, input scl, input sda);
    modport slave  (output sda_s_oe, input scl, input sda);
endinterface : pwi_bus_if

// *** core/pwi_fifo.sv ***
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes single clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
module pwi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // drain side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    // full and empty from pointer comparison
    assign in_ready_o  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o  = mem_q[rd_q[AW-1:0]];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    // pointers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end
endmodule : pwi_fifo

// *** core/pwi_master.sv ***
/*
 * bus master end: takes queued commands from a fifo and runs a write
 * (id, address, data) or read (id, data, nack) transaction with start and stop.
 * assumes it alone drives the link clock, generated by an enable divider.
 */
`timescale 1ns/1ps
module pwi_master
    import pwi_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // link
    pwi_bus_if.master        bus,
    // command: target select bits, direction, address and data
    input  wire logic [1:0]  cmd_sel_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_rd_i,
    input  wire logic [7:0]  cmd_addr_i,
    input  wire logic [7:0]  cmd_data_i,
    output logic             cmd_ready_o,
    // answer
    output logic             done_o,
    output logic             nack_o,
    output logic [7:0]       rd_data_o
);
    typedef enum logic [2:0] {
        MS_IDLE, MS_START, MS_BIT, MS_STOP
    } pwi_mstate_e;

    pwi_mstate_e state_q;
    logic [$clog2(SCL_QTR_CYC)-1:0] div_q;
    logic        tick;
    logic [1:0]  phase_q;
    logic [1:0]  sda_sync_q;
    logic [3:0]  bit_q;
    logic [1:0]  byte_q;
    logic [7:0]  sh_q;
    logic [7:0]  rx_q;
    logic        scl_oe_q;
    logic        sda_oe_q;
    logic        nack_q;
    logic        done_q;
    logic [7:0]  rd_data_q;
    logic        f_valid;
    logic        f_ready;
    logic [CMD_W+1:0] f_data;
    logic [1:0]  nbytes;

    // command queue; drained one transaction at a time
    pwi_fifo #(.WIDTH(CMD_W+2), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (cmd_valid_i),
        .in_data_i   ({cmd_sel_i, cmd_rd_i, cmd_addr_i, cmd_data_i}),
        .in_ready_o  (cmd_ready_o),
        .out_valid_o (f_valid),
        .out_data_o  (f_data),
        .out_ready_i (f_ready)
    );
    assign f_ready = (state_q == MS_STOP) && tick && phase_q == 2'h3;
    assign nbytes  = f_data[CMD_W-1] ? 2'h2 : 2'h3;  // read: id + one byte

    // quarter-period enable divider
    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == MS_IDLE) begin
            div_q <= '0;
        end else begin
            div_q <= (div_q == ($clog2(SCL_QTR_CYC))'(SCL_QTR_CYC - 1)) ? '0 : div_q + 1'b1;
        end
    end
    assign tick = div_q == ($clog2(SCL_QTR_CYC))'(SCL_QTR_CYC - 1);

    // data line read back through two flops
    always_ff @(posedge clk_i) begin
        if (rst_i) sda_sync_q <= 2'h3;
        else       sda_sync_q <= {sda_sync_q[0], bus.sda};
    end

    // transaction sequencer: phase 0 low/drive, 1 rise, 2 high/sample, 3 fall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q  <= MS_IDLE;
            phase_q  <= 2'h0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            bit_q    <= 4'h0;
            byte_q   <= 2'h0;
            sh_q     <= 8'h00;
            rx_q     <= 8'h00;
            nack_q   <= 1'b0;
            done_q   <= 1'b0;
            rd_data_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                MS_IDLE: begin
                    if (f_valid) begin
                        state_q <= MS_START;
                        phase_q <= 2'h0;
                        nack_q  <= 1'b0;
                        sh_q    <= {ID_PATTERN, f_data[CMD_W+1:CMD_W], f_data[CMD_W-1]};
                    end
                end
                MS_START: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    if (phase_q == 2'h1) sda_oe_q <= 1'b1;     // sda falls, scl high
                    if (phase_q == 2'h3) begin
                        scl_oe_q <= 1'b1;
                        state_q  <= MS_BIT;
                        bit_q    <= 4'h0;
                        byte_q   <= 2'h0;
                    end
                end
                MS_BIT: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    case (phase_q)
                        2'h0: begin   // drive while clock low, msb first
                            if (bit_q == 4'h8) begin
                                // ack slot: released; on the read data byte this is the nack
                                sda_oe_q <= 1'b0;
                            end else if (f_data[CMD_W-1] && byte_q == 2'h1) begin
                                sda_oe_q <= 1'b0;                    // receiving
                            end else begin
                                sda_oe_q <= ~sh_q[7];
                            end
                        end
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: begin
                            if (bit_q == 4'h8) begin
                                if (!(f_data[CMD_W-1] && byte_q == 2'h1) && sda_sync_q[1]) begin
                                    nack_q <= 1'b1;
                                end
                            end else begin
                                rx_q <= {rx_q[6:0], sda_sync_q[1]};
                                sh_q <= {sh_q[6:0], 1'b0};
                            end
                        end
                        default: begin
                            scl_oe_q <= 1'b1;
                            if (bit_q == 4'h8) begin
                                bit_q  <= 4'h0;
                                byte_q <= byte_q + 2'h1;
                                sh_q   <= (byte_q == 2'h0) ? f_data[15:8] : f_data[7:0];
                                if (byte_q + 2'h1 == nbytes || nack_q) begin
                                    state_q <= MS_STOP;
                                    if (f_data[CMD_W-1]) rd_data_q <= rx_q;
                                end
                            end else begin
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    endcase
                end
                MS_STOP: if (tick) begin
                    phase_q <= phase_q + 2'h1;
                    if (phase_q == 2'h0) sda_oe_q <= 1'b1;
                    if (phase_q == 2'h1) scl_oe_q <= 1'b0;
                    if (phase_q == 2'h2) sda_oe_q <= 1'b0;     // sda rises, scl high
                    if (phase_q == 2'h3) begin
                        state_q <= MS_IDLE;
                        done_q  <= 1'b1;
                    end
                end
                default: state_q <= MS_IDLE;
            endcase
        end
    end

    assign bus.scl_oe   = scl_oe_q;
    assign bus.sda_m_oe = sda_oe_q;
    assign done_o       = done_q;
    assign nack_o       = nack_q;
    assign rd_data_o    = rd_data_q;
endmodule : pwi_master

// *** bench/pwi_link_props.sv ***
/*
 * link checker: watches the resolved two-wire lines and the driver enables.
 * assumes one system clock with a synchronous active-high reset.
 */
`timescale 1ns/1ps
module pwi_link_props
    import pwi_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // link enables and resolved lines
    input  wire logic scl_oe,
    input  wire logic sda_m_oe,
    input  wire logic sda_s_oe,
    input  wire logic scl,
    input  wire logic sda
);
    logic       scl_q, sda_q, frame_q, rd_q, ack_q;
    logic [5:0] cnt_q;
    logic [7:0] sh_q;
    logic       rise, start, stop;

    // edge and frame-marker detect on the raw lines
    assign rise  = scl & ~scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop  = scl & scl_q & ~sda_q & sda;

    // line history
    always_ff @(posedge clk_i) begin
        scl_q <= rst_i ? 1'b1 : scl;
        sda_q <= rst_i ? 1'b1 : sda;
    end

    // frame flag and count of clock rises since the last start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_q <= 1'b0;
            cnt_q   <= 6'h00;
        end else if (start) begin
            frame_q <= 1'b1;
            cnt_q   <= 6'h00;
        end else begin
            if (stop) frame_q <= 1'b0;
            if (rise) cnt_q <= cnt_q + 6'h01;
        end
    end

    // shifted byte, direction bit and id acknowledge
    always_ff @(posedge clk_i) begin
        if (rise) sh_q <= {sh_q[6:0], sda};
        if (rise && cnt_q == 6'h08) begin
            rd_q  <= sh_q[0];
            ack_q <= ~sda;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_slave_lowclk:
        assert property ($changed(sda_s_oe) |-> !scl) else $error("slave moved data while clock high");
    a_drive_after_fall:
        assert property ($rose(sda_s_oe) |-> $past(scl_oe, 2)) else $error("slave drove before clock fell");
    a_quiet_reset:
        assert property ($fell(rst_i) |-> !sda_s_oe ##1 !sda_s_oe) else $error("slave drives after reset");
    a_idle_released:
        assert property (!frame_q |-> !sda_s_oe) else $error("slave drives outside a frame");
    a_first_drive:
        assert property ($rose(sda_s_oe) |-> cnt_q >= 6'h08) else $error("slave drove before eight bits");
    a_id_match:
        assert property (rise && cnt_q == 6'h08 && sda_s_oe |-> sh_q[7:3] == ID_PATTERN)
        else $error("slave acknowledged a foreign id");
    a_read_msb_zero:
        assert property (rise && cnt_q == 6'h09 && rd_q && ack_q |-> !sda)
        else $error("read byte msb not zero");
    a_read_one_byte:
        assert property (rise && cnt_q == 6'h11 && rd_q && ack_q |-> !sda_s_oe)
        else $error("slave held data in master ack slot");
    a_write_acks:
        assert property (rise && (cnt_q == 6'h11 || cnt_q == 6'h1a) && !rd_q && ack_q |-> sda_s_oe)
        else $error("slave missed a write acknowledge");
endmodule : pwi_link_props

// *** bench/testbench.sv ***
/*
 * testbench: master and wiper slave joined by the link, fed queued commands.
 * assumes the master makes the link clock; four transactions fit the run.
 */
`timescale 1ns/1ps
module testbench;
    import pwi_pkg::*;
    logic       clk_i     = 1'b0;
    logic       rst_i     = 1'b1;
    logic [1:0] pins      = 2'h0;
    logic [1:0] cmd_sel   = 2'h0;
    logic       cmd_valid = 1'b0;
    logic       cmd_rd    = 1'b0;
    logic [7:0] cmd_addr  = 8'h00;
    logic [7:0] cmd_data  = 8'h00;
    logic       cmd_ready, done, nack, standby;
    logic [7:0] rd_data;
    logic [6:0] wiper, exp_w;
    logic [1:0] sel_a  [4];
    logic       rd_a   [4];
    logic [7:0] addr_a [4];
    logic [7:0] data_a [4];
    int         n_fail  = 0;
    int         n_tests = 0;

    pwi_bus_if bus ();
    pwi_master pwi_master_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus.master),
        .cmd_sel_i(cmd_sel), .cmd_valid_i(cmd_valid), .cmd_rd_i(cmd_rd),
        .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
        .done_o(done), .nack_o(nack), .rd_data_o(rd_data));
    pwi_slave pwi_slave_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus.slave),
        .addr_select_hi_pin_i(pins[1]), .addr_select_lo_pin_i(pins[0]),
        .wiper_o(wiper), .standby_o(standby));
    pwi_link_props pwi_link_props_inst (.clk_i(clk_i), .rst_i(rst_i), .scl_oe(bus.scl_oe),
        .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));

    // system clock
    always #2.5 clk_i = ~clk_i;

    // expected wiper after one command
    function automatic logic [6:0] next_wiper(input logic [6:0] w, input logic hit,
                                              input logic rd, input logic [7:0] a,
                                              input logic [7:0] d);
        return (hit && !rd && a == WIPER_ADDR) ? d[6:0] : w;
    endfunction : next_wiper

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_done();
        int k;
        k = 0;
        while (done !== 1'b1 && k < 30000) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        if (k >= 30000) n_fail++;
    endtask : wait_done

    task automatic give_verdict();
        $display("tests=%0d failures=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // main sequence: queue four commands back to back, then check each result
    initial begin
        void'($urandom(82908));
        repeat (2) @(posedge clk_i);
        #1 rst_i = 1'b0;
        pins = 2'($urandom);
        check({1'b0, wiper}, {1'b0, WIPER_RESET});
        check({7'h00, standby}, 8'h01);
        check({7'h00, bus.sda_s_oe}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            sel_a[i]  = (i == 2) ? ~pins : pins;
            rd_a[i]   = (i == 3);
            addr_a[i] = (i == 1) ? 8'h01 + 8'($urandom % 255) : WIPER_ADDR;
            data_a[i] = 8'($urandom) | ((i == 0) ? 8'h80 : 8'h00);
        end
        @(posedge clk_i);
        #1;
        for (int i = 0; i < 4; i++) begin
            cmd_sel   = sel_a[i];
            cmd_rd    = rd_a[i];
            cmd_addr  = addr_a[i];
            cmd_data  = data_a[i];
            cmd_valid = 1'b1;
            while (cmd_ready !== 1'b1) begin
                @(posedge clk_i);
                #1;
            end
            @(posedge clk_i);
            #1;
        end
        cmd_valid = 1'b0;
        exp_w = WIPER_RESET;
        for (int i = 0; i < 4; i++) begin
            wait_done();
            check({7'h00, nack}, {7'h00, sel_a[i] != pins});
            repeat (8) @(posedge clk_i);
            #1;
            if (rd_a[i]) check(rd_data, {1'b0, exp_w});
            exp_w = next_wiper(exp_w, sel_a[i] == pins, rd_a[i], addr_a[i], data_a[i]);
            check({1'b0, wiper}, {1'b0, exp_w});
            if (sel_a[i] == pins) check({7'h00, standby}, 8'h01);
            check({6'h00, bus.scl, bus.sda}, 8'h03);
        end
        give_verdict();
    end

    // watchdog against a hung link
    initial begin
        #480000;
        n_fail++;
        give_verdict();
    end
endmodule : testbench
